// ---- rtl/pmt8_pkg.sv ----
// pmt8_pkg: register map, field layout, reset values and encodings of the
// period match timer. assumes an 8-bit register set reached over 32-bit apb.
package pmt8_pkg;
    // register indexes as printed; byte address is four times the index
    localparam logic [7:0] idx_global_interrupt_control = 8'h0B;
    localparam logic [7:0] idx_peripheral_flag_reg = 8'h0C;
    localparam logic [7:0] idx_count_value = 8'h11;
    localparam logic [7:0] idx_timer_control = 8'h12;
    localparam logic [7:0] idx_peripheral_enable_reg = 8'h8C;
    localparam logic [7:0] idx_period_limit = 8'h92;
    localparam int addr_width = 10;
    // field positions
    localparam int run_enable_bit = 2;
    localparam int in_div_lsb = 0;
    localparam int out_div_lsb = 3;
    localparam int match_flag_bit = 1;
    // implemented bits of the control register
    localparam logic [7:0] control_mask = 8'h7F;
    // reset values
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [7:0] period_reset = 8'hFF;
    localparam logic [7:0] control_reset = 8'h00;
    localparam logic [7:0] flag_reset = 8'h00;
    localparam logic [7:0] enable_reset = 8'h00;
    localparam logic [7:0] global_reset = 8'h00;
    // prescale divide counts (terminal values)
    localparam logic [3:0] pre_term_1 = 4'h0;
    localparam logic [3:0] pre_term_4 = 4'h3;
    localparam logic [3:0] pre_term_16 = 4'hF;
    // the core instruction clock is the bus clock divided by four
    localparam logic [1:0] inst_div_term = 2'h3;
    typedef enum logic [1:0] {
        pmt8_div1_type_v = 2'b00,
        pmt8_div4_type_v = 2'b01
    } pmt8_in_div_type;
endpackage

// ---- rtl/pmt8_scaler.sv ----
// pmt8_scaler: 4-bit divider, out_tick on every (ratio+1)-th input tick.
// assumes tick is a single cycle pulse and clear takes priority.
`timescale 1ns/1ps
module pmt8_scaler (
    input wire logic pclk,
    input wire logic presetn,
    pmt8_tick_if.scaler port
);
    logic [3:0] count;
    // terminal count reached with this tick
    assign port.out_tick = port.tick && (count == port.ratio) && !port.clear;
    // count ticks, wrap at the selected terminal value
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count <= 4'h0;
        end else if (port.clear) begin
            count <= 4'h0;
        end else if (port.tick) begin
            if (count == port.ratio) begin
                count <= 4'h0;
            end else begin
                count <= count + 4'h1;
            end
        end
    end
endmodule

// ---- rtl/pmt8_tick_if.sv ----
// pmt8_tick_if: carries tick and clear between the timer top and its scalers.
// assumes a single clock domain shared by both ends.
`timescale 1ns/1ps
interface pmt8_tick_if;
    logic tick;
    logic clear;
    logic [3:0] ratio;
    logic out_tick;
    modport ctrl (output tick, output clear, output ratio, input out_tick);
    modport scaler (input tick, input clear, input ratio, output out_tick);
endinterface

// ---- rtl/pmt8_timer.sv ----
// pmt8_timer: 8-bit period match timer with prescaler and postscaler, apb slave.
// assumes pclk is the core clock; apb master follows the usual two-phase protocol.
// register map, the byte address is four times the index
// 0x0B global_interrupt_control: plain storage, no effect on this block
// 0x0C peripheral_flag_reg: bit 1 is match_event_flag, hardware set wins
// 0x11 count_value: live count, a write restarts both scalers
// 0x12 timer_control: bits 6:3 output divider, bit 2 run, bits 1:0 input divider
// 0x8C peripheral_enable_reg: bit 1 is match_event_enable
// 0x92 period_limit: match value, all ones after reset
//
// bus timing: pready is always high, so every access ends at its first edge;
// read data is captured at the setup edge and stands until the next read;
// a misaligned or unmapped access raises pslverr; a write changes nothing, a read still captures read data.
//
// count timing: one instruction tick every four pclk, free running from reset;
// a control write restarts both scalers but keeps that four cycle phase, so the
// first prescaled tick after a write comes one to four pclk later when input divider code 0 (divide by one) is selected.
`timescale 1ns/1ps
module pmt8_timer (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmt8_pkg::addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic sync_serial_port_shift_tick,
    output logic [7:0] capture_compare_pwm_unit_timebase,
    output logic capture_compare_pwm_unit_period_match,
    output logic match_event_irq
);
    // software visible registers and the next count value
    logic [7:0] count_value;
    logic [7:0] next_count;
    logic [7:0] period_limit;
    logic [7:0] timer_control;
    logic [7:0] peripheral_flag_reg;
    logic [7:0] peripheral_enable_reg;
    logic [7:0] global_interrupt_control;

    // tick chain from the instruction clock to the period match
    logic [1:0] inst_count;
    logic inst_tick;
    logic run_tick;
    logic pre_tick;
    logic match;

    // bus decode
    logic access;
    logic wr;
    logic mapped;
    logic wr_count;
    logic wr_control;
    logic wr_flag;
    logic [7:0] sel_idx;

    // scaler ratio and the links to the two scaler instances
    logic [3:0] pre_term;
    pmt8_tick_if pre_bus ();
    pmt8_tick_if post_bus ();

    // word index of a byte address; low two bits must be zero
    function automatic logic [7:0] word_index(input logic [pmt8_pkg::addr_width-1:0] a);
        word_index = a[pmt8_pkg::addr_width-1:2];
    endfunction

    // decode whether an index names a mapped register
    function automatic logic is_mapped(input logic [7:0] i);
        is_mapped = (i == pmt8_pkg::idx_global_interrupt_control)
            || (i == pmt8_pkg::idx_peripheral_flag_reg)
            || (i == pmt8_pkg::idx_count_value)
            || (i == pmt8_pkg::idx_timer_control)
            || (i == pmt8_pkg::idx_peripheral_enable_reg)
            || (i == pmt8_pkg::idx_period_limit);
    endfunction

    // value of the register at an index, zero where nothing is mapped
    function automatic logic [7:0] read_value(input logic [7:0] i);
        unique case (i)
            pmt8_pkg::idx_global_interrupt_control: read_value = global_interrupt_control;
            pmt8_pkg::idx_peripheral_flag_reg: read_value = peripheral_flag_reg;
            pmt8_pkg::idx_count_value: read_value = count_value;
            pmt8_pkg::idx_timer_control: read_value = timer_control;
            pmt8_pkg::idx_peripheral_enable_reg: read_value = peripheral_enable_reg;
            pmt8_pkg::idx_period_limit: read_value = period_limit;
            default: read_value = 8'h00;
        endcase
    endfunction

    // elaboration checks: refuse constants that the logic cannot serve
    generate
        if (pmt8_pkg::addr_width != 10) begin : g_bad_addr_width
            $error("pmt8_timer needs a 10 bit byte address");
        end
        if (pmt8_pkg::run_enable_bit > 7) begin : g_bad_run_bit
            $error("pmt8_timer run enable bit lies outside the control byte");
        end
        if (pmt8_pkg::match_flag_bit > 7) begin : g_bad_flag_bit
            $error("pmt8_timer match flag bit lies outside the flag byte");
        end
        if (pmt8_pkg::in_div_lsb + 2 > 8) begin : g_bad_in_div
            $error("pmt8_timer input divider field lies outside the control byte");
        end
        if (pmt8_pkg::out_div_lsb + 4 > 8) begin : g_bad_out_div
            $error("pmt8_timer output divider field lies outside the control byte");
        end
        if (pmt8_pkg::control_mask[7] != 1'b0) begin : g_bad_mask
            $error("pmt8_timer top control bit must stay unimplemented");
        end
        if (pmt8_pkg::run_enable_bit < pmt8_pkg::in_div_lsb + 2
            || pmt8_pkg::run_enable_bit >= pmt8_pkg::out_div_lsb) begin : g_bad_layout
            $error("pmt8_timer control fields overlap");
        end
    endgenerate

    // apb access decode, zero wait states
    assign access = psel && penable;
    assign sel_idx = word_index(paddr);
    assign mapped = is_mapped(sel_idx) && (paddr[1:0] == 2'b00);
    assign wr = access && pwrite && mapped;
    assign wr_count = wr && (sel_idx == pmt8_pkg::idx_count_value);
    assign wr_control = wr && (sel_idx == pmt8_pkg::idx_timer_control);
    assign wr_flag = wr && (sel_idx == pmt8_pkg::idx_peripheral_flag_reg);
    assign pready = 1'b1;
    assign pslverr = access && !mapped;

    // instruction clock: one tick every four core clocks
    // not cleared by register writes, so the tick phase is kept
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            inst_count <= 2'h0;
        end else begin
            inst_count <= inst_count + 2'h1;
        end
    end
    assign inst_tick = (inst_count == pmt8_pkg::inst_div_term);

    // prescaler ratio from input_divider_select
    always_comb begin
        unique case (timer_control[pmt8_pkg::in_div_lsb +: 2])
            pmt8_pkg::pmt8_div1_type_v: pre_term = pmt8_pkg::pre_term_1;
            pmt8_pkg::pmt8_div4_type_v: pre_term = pmt8_pkg::pre_term_4;
            default: pre_term = pmt8_pkg::pre_term_16;
        endcase
    end

    // prescaler runs only while enabled, cleared on count or control write
    assign run_tick = inst_tick && timer_control[pmt8_pkg::run_enable_bit];
    assign pre_bus.tick = run_tick;
    assign pre_bus.clear = wr_count || wr_control;
    assign pre_bus.ratio = pre_term;
    assign pre_tick = pre_bus.out_tick;

    pmt8_scaler u_prescale (
        .pclk(pclk),
        .presetn(presetn),
        .port(pre_bus)
    );

    // period match: counter equals period on a prescaled tick
    assign match = pre_tick && (count_value == period_limit);

    // postscaler divides match events by code plus one
    assign post_bus.tick = match;
    assign post_bus.clear = wr_count || wr_control;
    assign post_bus.ratio = timer_control[pmt8_pkg::out_div_lsb +: 4];

    pmt8_scaler u_postscale (
        .pclk(pclk),
        .presetn(presetn),
        .port(post_bus)
    );

    // next count: software write wins, else wrap on match or step on a tick
    always_comb begin
        next_count = count_value;
        if (wr_count) begin
            next_count = pwdata[7:0];
        end else if (match) begin
            next_count = 8'h00;
        end else if (pre_tick) begin
            next_count = count_value + 8'h01;
        end
    end

    // counter register, cleared by every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_value <= pmt8_pkg::count_reset;
        end else begin
            count_value <= next_count;
        end
    end

    // period register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            period_limit <= pmt8_pkg::period_reset;
        end else if (wr && sel_idx == pmt8_pkg::idx_period_limit) begin
            period_limit <= pwdata[7:0];
        end
    end

    // control register, top bit unimplemented; count untouched here
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control <= pmt8_pkg::control_reset;
        end else if (wr_control) begin
            timer_control <= pwdata[7:0] & pmt8_pkg::control_mask;
        end
    end

    // peripheral flags: hardware set beats software write
    // a written one sets a flag as well, so software may raise it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_flag_reg <= pmt8_pkg::flag_reset;
        end else begin
            if (wr_flag) begin
                peripheral_flag_reg <= pwdata[7:0];
            end
            if (post_bus.out_tick) begin
                peripheral_flag_reg[pmt8_pkg::match_flag_bit] <= 1'b1;
            end
        end
    end

    // peripheral enables, plain storage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_enable_reg <= pmt8_pkg::enable_reset;
        end else if (wr && sel_idx == pmt8_pkg::idx_peripheral_enable_reg) begin
            peripheral_enable_reg <= pwdata[7:0];
        end
    end

    // global interrupt control, plain storage with no effect in this block
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            global_interrupt_control <= pmt8_pkg::global_reset;
        end else if (wr && sel_idx == pmt8_pkg::idx_global_interrupt_control) begin
            global_interrupt_control <= pwdata[7:0];
        end
    end

    // read data register, loaded in the setup phase
    // the value is a snapshot taken one edge before the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= {24'h000000, read_value(word_index(paddr))};
        end
    end

    // unscaled match pulse for the sync serial port shift clock
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_serial_port_shift_tick <= 1'b0;
        end else begin
            sync_serial_port_shift_tick <= match;
        end
    end

    // pwm time base: registered count and its period pulse
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_compare_pwm_unit_period_match <= 1'b0;
            capture_compare_pwm_unit_timebase <= 8'h00;
        end else begin
            capture_compare_pwm_unit_period_match <= match;
            capture_compare_pwm_unit_timebase <= count_value;
        end
    end

    // interrupt request while flag and enable are both set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_event_irq <= 1'b0;
        end else begin
            match_event_irq <= peripheral_flag_reg[pmt8_pkg::match_flag_bit]
                && peripheral_enable_reg[pmt8_pkg::match_flag_bit];
        end
    end
endmodule

// ---- test/pmt8_timer_sva.sv ----
// pmt8_timer_sva: port level checks of the period match timer.
// assumes it is bound to pmt8_timer and sees only that module's ports.
`timescale 1ns/1ps
module pmt8_timer_sva (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [pmt8_pkg::addr_width-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic sync_serial_port_shift_tick,
    input wire logic [7:0] capture_compare_pwm_unit_timebase,
    input wire logic capture_compare_pwm_unit_period_match,
    input wire logic match_event_irq
);
    // short aliases and the decode of answering addresses
    wire st = sync_serial_port_shift_tick;
    wire [7:0] tb = capture_compare_pwm_unit_timebase;
    wire wrq = psel && pwrite;
    wire acc = psel && penable;
    wire irq = match_event_irq;
    wire hit = paddr inside {10'h02C, 10'h030, 10'h044, 10'h048, 10'h230, 10'h248};
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (pready) else $error("pready low");
    AST_ERR_OK: assert property (acc && hit |-> !pslverr) else $error("pslverr");
    AST_ERR_BAD: assert property (acc && !hit |-> pslverr) else $error("no pslverr");
    AST_UPPER: assert property (prdata[31:8] == 24'h000000) else $error("prdata high");
    AST_SAME: assert property (st == capture_compare_pwm_unit_period_match) else $error("pwm");
    AST_GAP: assert property (st |=> !st [*3]) else $error("tick spacing");
    AST_WRAP: assert property (st |-> ##[0:2] tb == 8'h00) else $error("no wrap");
    AST_STEP: assert property ($changed(tb) && !$past(wrq) && !$past(wrq, 2)
        |-> tb == $past(tb) + 8'h01 || tb == 8'h00) else $error("bad step");
    AST_IRQ_CAUSE: assert property ($rose(irq) |-> $past(st) || $past(st, 2) || $past(st, 3)
        || $past(wrq) || $past(wrq, 2)) else $error("stray irq");
    AST_IRQ_HOLD: assert property (irq && !psel && !$past(psel) |=> irq) else $error("irq");
    C_TICK: cover property (st);
    C_IRQ: cover property ($rose(irq));
    C_ERR: cover property (acc && !hit);
endmodule
bind pmt8_timer pmt8_timer_sva u_pmt8_timer_sva (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .sync_serial_port_shift_tick,
    .capture_compare_pwm_unit_timebase, .capture_compare_pwm_unit_period_match,
    .match_event_irq);

// ---- test/pmt8_timer_tb_top.sv ----
// pmt8_timer_tb_top: directed scenarios for the period match timer.
// assumes a zero wait state apb slave and a 100 MHz pclk.
`timescale 1ns/1ps
module pmt8_timer_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [pmt8_pkg::addr_width-1:0] paddr = '0;
    logic [31:0] pwdata = 32'h00000000;
    logic [31:0] prdata;
    logic [31:0] rdv;
    logic pready;
    logic shift;
    logic irq;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    localparam logic [7:0] cnt = pmt8_pkg::idx_count_value;
    localparam logic [7:0] per = pmt8_pkg::idx_period_limit;
    localparam logic [7:0] ctl = pmt8_pkg::idx_timer_control;
    localparam logic [7:0] flg = pmt8_pkg::idx_peripheral_flag_reg;
    localparam logic [7:0] ena = pmt8_pkg::idx_peripheral_enable_reg;
    pmt8_timer u_pmt8_timer (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr(), .sync_serial_port_shift_tick(shift),
        .capture_compare_pwm_unit_timebase(), .capture_compare_pwm_unit_period_match(),
        .match_event_irq(irq));
    // clock and hang ceiling
    always #5 pclk = ~pclk;
    always @(posedge pclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            fails++;
            end_of_test();
        end
    end
    task automatic end_of_test();
        if (fails == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    // one apb transfer, held until pready is seen at the access edge
    task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h000000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rdv = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        check(rdv, {24'h000000, exp});
    endtask
    // cycles from one shift tick to the next
    task automatic gap(output int n);
        n = 1;
        @(posedge pclk);
        while (shift !== 1'b1) begin
            @(posedge pclk);
            n++;
        end
    endtask
    // reset values, storage, unmapped place, stopped counter
    task automatic t_regs();
        rd(cnt, 8'h00);
        rd(per, 8'hFF);
        rd(ctl, 8'h00);
        rd(flg, 8'h00);
        wr(per, 8'h5A);
        rd(per, 8'h5A);
        wr(8'h20, 8'h77);
        rd(8'h20, 8'h00);
        wr(cnt, 8'hC3);
        wr(ctl, 8'hFB);
        rd(ctl, 8'h7B);
        repeat (40) @(posedge pclk);
        rd(cnt, 8'hC3);
    endtask
    // match interval for every input divider code
    task automatic t_div();
        int n;
        wr(cnt, 8'h00);
        for (int c = 0; c < 4; c++) begin
            wr(per, 8'h02);
            wr(ctl, {6'b000001, 2'(c)});
            gap(n);
            gap(n);
            check(32'(n), 32'(12 * (c == 0 ? 1 : c == 1 ? 4 : 16)));
        end
    endtask
    // matches needed to raise the flag for several output divider codes
    task automatic t_post();
        int n;
        wr(per, 8'h00);
        wr(ena, 8'h02);
        for (int c = 0; c < 16; c += 5) begin
            wr(ctl, 8'h00);
            wr(flg, 8'h00);
            wr(ctl, {1'b0, 4'(c), 3'b100});
            n = 0;
            while (irq !== 1'b1) begin
                @(posedge pclk);
                if (shift === 1'b1) n++;
            end
            repeat (2) @(posedge pclk) if (shift === 1'b1) n++;
            check(32'(n), 32'(c + 1));
        end
        wr(ctl, 8'h00);
        wr(ena, 8'h00);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h00000000);
        rd(flg, 8'h02);
    endtask
    // a count write part way through restarts the postscaler
    task automatic t_cnt_clear();
        int n;
        wr(flg, 8'h00);
        wr(ena, 8'h02);
        wr(ctl, 8'h1C);
        gap(n);
        gap(n);
        wr(cnt, 8'h00);
        n = 0;
        while (irq !== 1'b1) begin
            @(posedge pclk);
            if (shift === 1'b1) n++;
        end
        check(32'(n), 32'h00000004);
    endtask
    initial begin
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_div();
        t_post();
        t_cnt_clear();
        wr(per, 8'h80);
        wr(cnt, 8'h3C);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        rd(cnt, 8'h00);
        rd(per, 8'hFF);
        rd(ctl, 8'h00);
        rd(flg, 8'h00);
        end_of_test();
    end
endmodule
